// *** hfo_map.svh ***
// Register map, field positions, reset values and codes of the H-F oscillator control
// Assumes inclusion by bare name from the modules and bench of this block
`ifndef HFO_MAP_SVH
`define HFO_MAP_SVH

`define HFO_CTRL_ADDR 8'hB2
`define HFO_CTRL_RESET 8'hC0
`define HFO_BIT_ENABLE 7
`define HFO_BIT_READY 6
`define HFO_BIT_SUSPEND 5
`define HFO_BIT_SYNC_BUSY 4
`define HFO_UNUSED_VALUE 2'h0
`define HFO_DIV_RESET 2'h0
`define HFO_CLKSEL_DIVIDED 3'h0
`define HFO_CLKSEL_DIRECT 3'h3
`define HFO_DIVCODE_16 2'h0
`define HFO_DIVCODE_8 2'h1
`define HFO_DIVCODE_4 2'h2
`define HFO_DIVCODE_2 2'h3
`define HFO_FACTOR_16 5'h10
`define HFO_FACTOR_8 5'h08
`define HFO_FACTOR_4 5'h04
`define HFO_FACTOR_2 5'h02
`define HFO_FACTOR_1 5'h01
`define HFO_FACTOR_RESET 5'h10
`define HFO_RESYNC_TICKS 2'h3
`define HFO_SYNC_RESET 7'h40
`define HFO_SYNC_OSC_STABLE 6
`define HFO_SYNC_TIMER_CLK 5
`define HFO_SYNC_T3_OVF 4
`define HFO_SYNC_CMP_OUT 3
`define HFO_SYNC_CMP_EN 2
`define HFO_SYNC_P1_MATCH 1
`define HFO_SYNC_P0_MATCH 0

`endif

// *** hfo_pkg.sv ***
// Types shared by the H-F oscillator control block
// Assumes hfo_map.svh is reachable on the include path
package hfo_pkg;
	typedef enum logic [1:0] {
		HFO_RUN = 2'b00,
		HFO_SUSPEND = 2'b01,
		HFO_RESYNC = 2'b10
	} hfo_mode_e;

	typedef struct packed {
		hfo_mode_e mode;
		logic enable;
		logic suspendBit;
		logic [1:0] divSel;
		logic freqReady;
		logic syncBusy;
		logic [1:0] tickCnt;
		logic [7:0] rdata;
		logic oscRun;
		logic cpuHold;
		logic [4:0] divFactor;
	} hfo_state_s;

	typedef struct packed {
		logic [6:0] stage1;
		logic [6:0] stage2;
		logic timerClkLast;
	} hfo_sync_s;
endpackage

// *** hfo_wake_if.sv ***
// Synchronised wake and status signals passed from the input synchroniser to the control
// Assumes both ends run on the same system clock
interface hfo_wake_if;
	logic wakeOther;
	logic wakeTimer;
	logic timerTick;
	logic oscStable;

	modport src (output wakeOther, output wakeTimer, output timerTick, output oscStable);
	modport dst (input wakeOther, input wakeTimer, input timerTick, input oscStable);
endinterface

// *** hfo_wake_sync.sv ***
// Two-flop synchronisers for wake sources, wake-timer clock and oscillator status
// Assumes all inputs are asynchronous to clock; clkEn freezes the chain
`include "hfo_map.svh"

module hfo_wake_sync
	import hfo_pkg::*;
(
	input wire logic clock, // System clock
	input wire logic arst_n, // Async reset, active low
	input wire logic clkEn, // Freezes state while low
	input wire logic port0Match, // Port 0 match event
	input wire logic port1Match, // Port 1 match event
	input wire logic cmp0Enable, // Comparator 0 enabled
	input wire logic cmp0Out, // Comparator 0 output
	input wire logic timer3Overflow, // Wake-up timer overflow
	input wire logic wakeTimerClk, // Wake-up timer clock
	input wire logic oscStable, // Oscillator at programmed frequency
	hfo_wake_if.src wake // Synchronised results
);
	hfo_sync_s state_reg;
	hfo_sync_s state_next;
	logic [6:0] s2;

	always_comb begin
		state_next = state_reg;
		if (clkEn) begin
			state_next.stage1 = {oscStable, wakeTimerClk, timer3Overflow, cmp0Out, cmp0Enable,
				port1Match, port0Match};
			state_next.stage2 = state_reg.stage1;
			state_next.timerClkLast = state_reg.stage2[`HFO_SYNC_TIMER_CLK];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= '{stage1: `HFO_SYNC_RESET, stage2: `HFO_SYNC_RESET, timerClkLast: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign s2 = state_reg.stage2;
	// Comparator wakes only while enabled and low
	assign wake.wakeOther = s2[`HFO_SYNC_P0_MATCH] | s2[`HFO_SYNC_P1_MATCH] |
		(s2[`HFO_SYNC_CMP_EN] & ~s2[`HFO_SYNC_CMP_OUT]);
	assign wake.wakeTimer = s2[`HFO_SYNC_T3_OVF];
	assign wake.timerTick = s2[`HFO_SYNC_TIMER_CLK] & ~state_reg.timerClkLast;
	assign wake.oscStable = s2[`HFO_SYNC_OSC_STABLE];
endmodule // hfo_wake_sync

// *** hfo_osc_control.sv ***
// Control and status register of the internal high-frequency oscillator
// Assumes a single-cycle SFR bus on clock and a clock that keeps running in suspend
`include "hfo_map.svh"

module hfo_osc_control
	import hfo_pkg::*;
(
	input wire logic clock, // System clock, 200 MHz
	input wire logic arst_n, // Async reset, active low
	input wire logic clkEn, // Freezes all state while low
	input wire logic [7:0] sfrAddr, // SFR address
	input wire logic sfrWrite, // SFR write strobe
	input wire logic sfrRead, // SFR read strobe
	input wire logic [7:0] sfrWdata, // SFR write data
	output logic [7:0] sfrRdata, // Read data, 00 when not selected
	input wire logic [2:0] sysClockSourceSelect, // System clock source select
	input wire logic port0Match, // Port 0 match event
	input wire logic port1Match, // Port 1 match event
	input wire logic cmp0Enable, // Comparator 0 enabled
	input wire logic cmp0Out, // Comparator 0 output
	input wire logic timer3Overflow, // Wake-up timer overflow
	input wire logic wakeTimerClk, // Wake-up timer clock
	input wire logic oscStable, // Analog oscillator settled
	output logic hfOscRun, // Oscillator run request
	output logic cpuHold, // Processor clock held
	output logic wakeTimerSyncBusy, // Timer registers unsafe
	output logic [4:0] hfDivideFactor // System clock divide factor
);
	hfo_state_s state_reg;
	hfo_state_s state_next;
	hfo_wake_if wake();
	logic ctrlSel;
	logic ctrlWrite;
	logic ctrlRead;

	function automatic logic [4:0] hfo_div_factor(input logic [2:0] clkSel,
		input logic [1:0] code);
		logic [4:0] f;
		f = `HFO_FACTOR_1;
		if (clkSel == `HFO_CLKSEL_DIVIDED) begin
			case (code)
				`HFO_DIVCODE_16: f = `HFO_FACTOR_16;
				`HFO_DIVCODE_8: f = `HFO_FACTOR_8;
				`HFO_DIVCODE_4: f = `HFO_FACTOR_4;
				`HFO_DIVCODE_2: f = `HFO_FACTOR_2;
				default: f = `HFO_FACTOR_16;
			endcase
		end
		return f;
	endfunction

	hfo_wake_sync u_sync (
		.clock(clock),
		.arst_n(arst_n),
		.clkEn(clkEn),
		.port0Match(port0Match),
		.port1Match(port1Match),
		.cmp0Enable(cmp0Enable),
		.cmp0Out(cmp0Out),
		.timer3Overflow(timer3Overflow),
		.wakeTimerClk(wakeTimerClk),
		.oscStable(oscStable),
		.wake(wake.src)
	);

	assign ctrlSel = (sfrAddr == `HFO_CTRL_ADDR);
	assign ctrlWrite = ctrlSel & sfrWrite;
	assign ctrlRead = ctrlSel & sfrRead;

	always_comb begin
		state_next = state_reg;
		if (clkEn) begin
			if (ctrlWrite) begin
				state_next.enable = sfrWdata[`HFO_BIT_ENABLE];
				state_next.divSel = sfrWdata[1:0];
			end
			case (state_reg.mode)
				HFO_RUN, HFO_RESYNC: begin
					if (ctrlWrite && sfrWdata[`HFO_BIT_SUSPEND]) begin
						state_next.mode = HFO_SUSPEND;
						state_next.suspendBit = 1'b1;
					end else if (state_reg.mode == HFO_RESYNC && wake.timerTick) begin
						if (state_reg.tickCnt == `HFO_RESYNC_TICKS - 2'h1) begin
							state_next.mode = HFO_RUN;
							state_next.syncBusy = 1'b0;
						end else begin
							state_next.tickCnt = state_reg.tickCnt + 2'h1;
						end
					end
				end
				HFO_SUSPEND: begin
					if (wake.wakeOther) begin
						state_next.mode = HFO_RESYNC;
						state_next.syncBusy = 1'b1;
						state_next.tickCnt = 2'h0;
						state_next.suspendBit = 1'b0;
					end else if (wake.wakeTimer) begin
						state_next.mode = state_reg.syncBusy ? HFO_RESYNC : HFO_RUN;
						state_next.suspendBit = 1'b0;
					end
				end
				default: begin
					state_next.mode = HFO_RUN;
				end
			endcase
			// Processor is only held, so it continues with the next instruction
			state_next.cpuHold = (state_next.mode == HFO_SUSPEND);
			state_next.oscRun = state_next.enable & ~state_next.cpuHold;
			state_next.freqReady = state_next.oscRun & wake.oscStable;
			state_next.divFactor = hfo_div_factor(sysClockSourceSelect,
				state_next.divSel);
			state_next.rdata = 8'h00;
			if (ctrlRead) begin
				state_next.rdata = {state_reg.enable, state_reg.freqReady,
					state_reg.suspendBit, state_reg.syncBusy, `HFO_UNUSED_VALUE,
					state_reg.divSel};
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= '{mode: HFO_RUN, enable: 1'b1, suspendBit: 1'b0,
				divSel: `HFO_DIV_RESET, freqReady: 1'b1, syncBusy: 1'b0, tickCnt: 2'h0,
				rdata: 8'h00, oscRun: 1'b1, cpuHold: 1'b0, divFactor: `HFO_FACTOR_RESET};
		end else begin
			state_reg <= state_next;
		end
	end

	assign sfrRdata = state_reg.rdata;
	assign hfOscRun = state_reg.oscRun;
	assign cpuHold = state_reg.cpuHold;
	assign wakeTimerSyncBusy = state_reg.syncBusy;
	assign hfDivideFactor = state_reg.divFactor;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	AST_OSC_FOLLOWS_ENABLE: assert property (hfOscRun == (state_reg.enable && !cpuHold))
		else $error("Oscillator run does not follow enable and suspend");
	AST_READY_NEEDS_RUN: assert property (state_reg.freqReady |-> hfOscRun)
		else $error("Frequency ready set while oscillator stopped");
	AST_SUSPEND_ENTRY: assert property (clkEn && ctrlWrite && sfrWdata[`HFO_BIT_SUSPEND] &&
		state_reg.mode == HFO_RUN |=> cpuHold && !hfOscRun && state_reg.suspendBit)
		else $error("Suspend write did not halt oscillator");
	AST_BUSY_READBACK: assert property (clkEn && ctrlRead |=>
		sfrRdata[`HFO_BIT_SYNC_BUSY] == $past(wakeTimerSyncBusy))
		else $error("Timer sync flag read back wrong");
	AST_RESYNC_ENTRY: assert property (clkEn && state_reg.mode == HFO_SUSPEND &&
		wake.wakeOther |=> wakeTimerSyncBusy && state_reg.tickCnt == 2'h0)
		else $error("Non-timer wake did not raise timer sync flag");
	AST_RESYNC_END: assert property (clkEn && state_reg.mode == HFO_RESYNC && wake.timerTick &&
		state_reg.tickCnt == 2'h2 && !ctrlWrite |=> !wakeTimerSyncBusy)
		else $error("Timer sync flag held past three timer clocks");
	AST_UNUSED_ZERO: assert property (sfrRdata[3:2] == 2'h0)
		else $error("Unused bits read nonzero");
	AST_DIVIDER: assert property (clkEn |=>
		hfDivideFactor == hfo_div_factor($past(sysClockSourceSelect), state_reg.divSel))
		else $error("Divide factor does not match select and field");
	AST_UNMAPPED_READ: assert property (clkEn && sfrRead && !ctrlSel |=> sfrRdata == 8'h00)
		else $error("Read of another address returned data");
	AST_WAKE_RELEASE: assert property (clkEn && state_reg.mode == HFO_SUSPEND &&
		(wake.wakeOther || wake.wakeTimer) |=> !cpuHold && !state_reg.suspendBit)
		else $error("Wake event did not end suspend");

	// Frozen clock enable leaves every flop alone
	AST_FREEZE_HOLDS: assert property (!clkEn |=> $stable(state_reg))
		else $error("State changed while clock enable low");
	// Read data stands for one cycle only
	AST_READ_ONE_CYCLE: assert property (clkEn && !ctrlRead |=> sfrRdata == 8'h00)
		else $error("Read data stood without a read");
	AST_ENABLE_WRITE: assert property (clkEn && ctrlWrite |=>
		state_reg.enable == $past(sfrWdata[`HFO_BIT_ENABLE]))
		else $error("Enable bit did not take written value");
	AST_DIV_WRITE: assert property (clkEn && ctrlWrite |=>
		state_reg.divSel == $past(sfrWdata[1:0]))
		else $error("Divider field did not take written value");
	// Wake inputs alone never bring the hold on
	AST_NO_HOLD_OUTSIDE: assert property (clkEn && state_reg.mode != HFO_SUSPEND &&
		!(ctrlWrite && sfrWdata[`HFO_BIT_SUSPEND]) |=> !cpuHold)
		else $error("Processor held without a suspend write");
	AST_READY_FOLLOWS: assert property (clkEn |=>
		state_reg.freqReady == (hfOscRun && $past(wake.oscStable)))
		else $error("Frequency ready does not follow run and stable");
	AST_SUSPEND_BIT_HOLD: assert property (state_reg.suspendBit == cpuHold)
		else $error("Suspend bit and processor hold disagree");
	// Busy flag only while resync is pending
	AST_BUSY_NOT_RUN: assert property (wakeTimerSyncBusy |-> state_reg.mode != HFO_RUN)
		else $error("Timer sync flag set in plain run");

	COV_SUSPEND: cover property (clkEn && ctrlWrite && sfrWdata[`HFO_BIT_SUSPEND]);
	COV_TIMER_WAKE: cover property (state_reg.mode == HFO_SUSPEND && wake.wakeTimer);
	COV_RESYNC_DONE: cover property (wakeTimerSyncBusy ##1 !wakeTimerSyncBusy);
	COV_CTRL_READ: cover property (clkEn && ctrlRead);
	COV_OTHER_WAKE: cover property (state_reg.mode == HFO_SUSPEND && wake.wakeOther);
endmodule // hfo_osc_control

// *** tb.sv ***
// Self-checking bench for the H-F oscillator control register block
// Assumes hfo_map.svh on the include path and the design files compiled first
`include "hfo_map.svh"

module tb
	import hfo_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed {
		logic [7:0] wdata;
		logic [2:0] sel;
		logic [7:0] rd;
		logic [7:0] outs;
	} hfo_row_s;

	logic clock, arst_n, clkEn, sfrWrite, sfrRead, port0Match, port1Match;
	logic cmp0Enable, cmp0Out, timer3Overflow, wakeTimerClk, oscStable;
	logic hfOscRun, cpuHold, wakeTimerSyncBusy;
	logic [7:0] sfrAddr, sfrWdata, sfrRdata;
	logic [2:0] sysClockSourceSelect;
	logic [4:0] hfDivideFactor;
	logic [7:0] outs;
	int nMismatch = 0;
	int samplesChecked = 0;
	int cycles = 0;
	hfo_row_s rows [8];

	// Run, hold, busy and divide factor packed for one compare
	assign outs = {hfOscRun, cpuHold, wakeTimerSyncBusy, hfDivideFactor};

	hfo_osc_control hfo_osc_control_inst (.clock(clock), .arst_n(arst_n), .clkEn(clkEn),
		.sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
		.sfrRdata(sfrRdata), .sysClockSourceSelect(sysClockSourceSelect),
		.port0Match(port0Match), .port1Match(port1Match), .cmp0Enable(cmp0Enable),
		.cmp0Out(cmp0Out), .timer3Overflow(timer3Overflow), .wakeTimerClk(wakeTimerClk),
		.oscStable(oscStable), .hfOscRun(hfOscRun), .cpuHold(cpuHold),
		.wakeTimerSyncBusy(wakeTimerSyncBusy), .hfDivideFactor(hfDivideFactor));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic report_and_stop();
		if (nMismatch == 0 && samplesChecked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			nMismatch++;
			report_and_stop();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nMismatch++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfrAddr <= a;
		sfrWdata <= d;
		sfrWrite <= 1'b1;
		@(posedge clock);
		sfrWrite <= 1'b0;
		#1;
	endtask

	task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		sfrAddr <= a;
		sfrRead <= 1'b1;
		@(posedge clock);
		sfrRead <= 1'b0;
		#1;
		check(sfrRdata, exp);
	endtask

	task automatic set_wake(input int k, input logic v);
		@(posedge clock);
		case (k)
			0: port0Match <= v;
			1: port1Match <= v;
			2: cmp0Enable <= v;
			default: timer3Overflow <= v;
		endcase
	endtask

	task automatic timer_edges(input int n);
		repeat (n) begin
			@(posedge clock);
			wakeTimerClk <= 1'b1;
			repeat (3) @(posedge clock);
			wakeTimerClk <= 1'b0;
			repeat (3) @(posedge clock);
		end
		#1;
	endtask

	initial begin
		int i;
		rows = '{'{8'h83, 3'h0, 8'hC3, 8'h82}, '{8'h82, 3'h0, 8'hC2, 8'h84},
			'{8'h81, 3'h0, 8'hC1, 8'h88}, '{8'hDC, 3'h0, 8'hC0, 8'h90},
			'{8'h83, 3'h3, 8'hC3, 8'h81}, '{8'h82, 3'h1, 8'hC2, 8'h81},
			'{8'h00, 3'h0, 8'h00, 8'h10}, '{8'h80, 3'h0, 8'hC0, 8'h90}};
		{arst_n, sfrWrite, sfrRead, port0Match, port1Match, cmp0Enable} = 6'h00;
		{cmp0Out, timer3Overflow, wakeTimerClk} = 3'h0;
		{clkEn, oscStable} = 2'b11;
		{sfrAddr, sfrWdata, sysClockSourceSelect} = 19'h0;
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		#1;
		check(outs, 8'h90);
		read_check(`HFO_CTRL_ADDR, `HFO_CTRL_RESET);
		foreach (rows[r]) begin
			sysClockSourceSelect <= rows[r].sel;
			sfr_write(`HFO_CTRL_ADDR, rows[r].wdata);
			read_check(`HFO_CTRL_ADDR, rows[r].rd);
			check(outs, rows[r].outs);
		end
		sfr_write(8'hB3, 8'h03);
		read_check(8'hB3, 8'h00);
		// Clock enable low freezes the register against a write
		@(posedge clock);
		clkEn <= 1'b0;
		sfr_write(`HFO_CTRL_ADDR, 8'h81);
		clkEn <= 1'b1;
		check(outs, 8'h90);
		read_check(`HFO_CTRL_ADDR, 8'hC0);
		// Read and write in one cycle return the old value
		@(posedge clock);
		sfrAddr <= `HFO_CTRL_ADDR;
		{sfrRead, sfrWrite, sfrWdata} <= {2'b11, 8'h83};
		@(posedge clock);
		{sfrRead, sfrWrite} <= 2'b00;
		#1;
		check(sfrRdata, 8'hC0);
		@(posedge clock);
		#1;
		check(sfrRdata, 8'h00);
		oscStable <= 1'b0;
		repeat (3) @(posedge clock);
		read_check(`HFO_CTRL_ADDR, 8'h83);
		oscStable <= 1'b1;
		sfr_write(`HFO_CTRL_ADDR, 8'h80);
		port0Match <= 1'b1;
		repeat (5) @(posedge clock);
		#1;
		check(outs, 8'h90);
		port0Match <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			sfr_write(`HFO_CTRL_ADDR, 8'hA0);
			check(outs, 8'h50);
			read_check(`HFO_CTRL_ADDR, 8'hA0);
			if (k == 2) begin
				cmp0Out <= 1'b1;
				set_wake(2, 1'b1);
				repeat (6) @(posedge clock);
				#1;
				check(outs, 8'h50);
				cmp0Out <= 1'b0;
			end else begin
				set_wake(k, 1'b1);
			end
			i = 0;
			while (cpuHold !== 1'b0 && i < 8) begin
				@(posedge clock);
				#1;
				i++;
			end
			check(outs, (k == 3) ? 8'h90 : 8'hB0);
			set_wake(k, 1'b0);
			read_check(`HFO_CTRL_ADDR, (k == 3) ? 8'hC0 : 8'hD0);
			if (k != 3) begin
				timer_edges(2);
				check(8'(wakeTimerSyncBusy), 8'h01);
				timer_edges(1);
				check(outs, 8'h90);
			end
		end
		// Reset in mid-run brings the register back to its reset value
		sfr_write(`HFO_CTRL_ADDR, 8'h03);
		arst_n <= 1'b0;
		@(posedge clock);
		#1;
		check(outs, 8'h90);
		arst_n <= 1'b1;
		read_check(`HFO_CTRL_ADDR, `HFO_CTRL_RESET);
		report_and_stop();
	end
endmodule // tb
